// ---- core/hcs_pkg.sv ----
package hcs_pkg;
    // buffer memory word addresses that this block services
    localparam logic [9:0]  ERR_CODE_ADDR     = 10'h007;
    localparam logic [9:0]  OFFLINE_CH_ADDR   = 10'h2dd;
    localparam logic [9:0]  PRESET_FN_ADDR    = 10'h2ec;
    localparam logic [15:0] ERR_CODE_CLEARED  = 16'h0000;
    localparam logic [15:0] ERR_CODE_SENSOR   = 16'h0016;
    // preset-function selections
    localparam logic [1:0]  PRESET_PARAM_FMT  = 2'h1;
    localparam logic [1:0]  PRESET_BUF_FMT    = 2'h2;
    localparam logic [1:0]  PRESET_SEQ_FMT    = 2'h3;
    // offline limit-switch behaviour
    localparam logic        OFFLINE_ALL_OFF   = 1'b0;
    localparam int          NUM_LS            = 8;
    localparam int          NUM_FAULT         = 5;
    localparam logic [7:0]  LS_RESET          = 8'h00;
    localparam logic [4:0]  FAULT_RESET       = 5'h00;

    typedef enum logic [2:0] {
        HCS_IDLE = 3'b001,
        HCS_POS  = 3'b010,
        HCS_JOG  = 3'b100
    } hcs_motion_t;
endpackage

// ---- core/hcs_sync.sv ----
`timescale 1ns/1ns
module hcs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,    // module clock
    input  wire logic         rst,    // async reset
    input  wire logic         ce,     // clock enable
    input  wire logic [W-1:0] d,      // asynchronous bits
    output logic      [W-1:0] q       // synchronised bits
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } hcs_sync_st_t;

    hcs_sync_st_t st_r;
    hcs_sync_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (ce)
        begin
            st_nxt.s1 = d;
            st_nxt.s2 = st_r.s1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign q = st_r.s2;
endmodule

// ---- core/hcs_edge.sv ----
`timescale 1ns/1ns
module hcs_edge #(
    parameter int W = 1
) (
    input  wire logic         clk,    // module clock
    input  wire logic         rst,    // async reset
    input  wire logic         ce,     // clock enable
    input  wire logic [W-1:0] d,      // synchronised level
    output logic      [W-1:0] rise    // one-cycle rising-edge pulse
);
    typedef struct packed {
        logic [W-1:0] prev;
    } hcs_edge_st_t;

    hcs_edge_st_t st_r;
    hcs_edge_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (ce)
            st_nxt.prev = d;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // prev is cleared at reset, so a level already high at release counts as an edge
    assign rise = d & ~st_r.prev & {W{ce}};
endmodule

// ---- core/hcs_host_cmd.sv ----
`timescale 1ns/1ns
module hcs_host_cmd
    import hcs_pkg::*;
(
    input  wire logic        clk,                        // module clock
    input  wire logic        rst,                        // async reset, active high
    input  wire logic        ce,                         // clock enable
    input  wire logic        host_ready_level,           // host ready (pin)
    input  wire logic        position_go_request,        // start positioning (pin)
    input  wire logic        position_halt_request,      // stop positioning (pin)
    input  wire logic        forward_jog_request,        // forward jog (pin)
    input  wire logic        reverse_jog_request,        // reverse jog (pin)
    input  wire logic        cam_output_enable,          // limit outputs enabled (pin)
    input  wire logic        fault_clear_request,        // error reset (pin)
    input  wire logic        preset1_inhibit_or_trigger, // preset 1 inhibit / command (pin)
    input  wire logic        preset2_inhibit,            // preset 2 inhibit (pin)
    input  wire logic        ext_preset1_in,             // external preset input 1 (pin)
    input  wire logic        ext_preset2_in,             // external preset input 2 (pin)
    input  wire logic [1:0]  preset_mode,                // preset-function parameter, same clock
    input  wire logic        offline_ls_hold,            // offline-channel parameter, same clock
    input  wire logic [7:0]  ls_setting,                 // limit switch states, same clock
    input  wire logic        pos_done,                   // positioning finished, same clock
    input  wire logic        channel_op_error,           // channel operation error, same clock
    input  wire logic [4:0]  fault_event,                // fault raise pulses, same clock
    input  wire logic [4:0]  fault_cause,                // fault causes still present
    input  wire logic        other_error,                // other module error, same clock
    input  wire logic [15:0] error_code_in,              // error code to store, same clock
    input  wire logic        error_code_load,            // store error_code_in, same clock
    input  wire logic        param_write,                // parameter write into buffer
    input  wire logic        ls_setting_write,           // limit setting write into buffer
    output logic             online_indicator,           // online state
    output logic             pos_active,                 // positioning in progress
    output logic             pos_start_pulse,            // one-cycle start strobe
    output logic             forward_drive_out,          // forward motor drive
    output logic             reverse_drive_out,          // reverse motor drive
    output logic [7:0]       ls_out,                     // limit switch outputs
    output logic             upper_overtravel_flag,      // fault flag
    output logic             lower_overtravel_flag,      // fault flag
    output logic             sensor_fault_flag,          // fault flag
    output logic             excess_correction_flag,     // fault flag
    output logic             excess_change_flag,         // fault flag
    output logic             any_fault_flag,             // summary fault flag
    output logic [15:0]      error_code,                 // error code word
    output logic             param_commit,               // copy params to internal memory
    output logic             ls_commit,                  // copy limit settings
    output logic             preset1_fire,               // perform preset from input 1 / cmd
    output logic             preset2_fire                // perform preset from input 2
);
    typedef struct packed {
        hcs_motion_t  mot;
        logic         online;
        logic         start;
        logic         fdrv;
        logic         rdrv;
        logic [7:0]   ls;
        logic [4:0]   flt;
        logic         any;
        logic [15:0]  code;
        logic         pcommit;
        logic         lcommit;
        logic         p1;
        logic         p2;
    } hcs_st_t;

    hcs_st_t st_r;
    hcs_st_t st_nxt;

    logic [10:0] pin_s;
    logic [4:0]  rise;
    logic        ready_s, go_s, halt_s, fjog_s, rjog_s, camen_s, clr_s, p1i_s, p2i_s;
    logic        ep1_s, ep2_s;
    logic        go_rise, clr_rise, p1_rise, ep_rise1, ep_rise2;

    function automatic logic mode_inhibits(input logic [1:0] m);
        mode_inhibits = (m == PRESET_PARAM_FMT) || (m == PRESET_BUF_FMT);
    endfunction

    hcs_sync #(.W(11)) hcs_sync_i (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   ({host_ready_level, position_go_request, position_halt_request,
                forward_jog_request, reverse_jog_request, cam_output_enable,
                fault_clear_request, preset1_inhibit_or_trigger, preset2_inhibit,
                ext_preset1_in, ext_preset2_in}),
        .q   (pin_s)
    );
    assign {ready_s, go_s, halt_s, fjog_s, rjog_s, camen_s, clr_s, p1i_s, p2i_s,
            ep1_s, ep2_s} = pin_s;

    // edge detect
    // all five edges share one detector, so each one is gated by ce alike
    hcs_edge #(.W(5)) hcs_edge_i (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .d    ({go_s, clr_s, p1i_s, ep1_s, ep2_s}),
        .rise (rise)
    );
    assign {go_rise, clr_rise, p1_rise, ep_rise1, ep_rise2} = rise;

    always_comb
    begin
        logic [4:0] flt_n;
        logic       sensor22;
        flt_n    = st_r.flt;
        sensor22 = 1'b0;
        st_nxt   = st_r;
        if (ce)
        begin
            st_nxt.online = ready_s;
            st_nxt.start  = 1'b0;
            sensor22      = st_r.code == ERR_CODE_SENSOR;
            unique case (st_r.mot)
                HCS_IDLE:
                begin
                    if (go_rise && ready_s && !halt_s && !channel_op_error && !sensor22
                        && !st_r.any)
                    begin
                        st_nxt.mot   = HCS_POS;
                        st_nxt.start = 1'b1;
                    end
                    else if (ready_s && !st_r.any && (fjog_s || rjog_s))
                        st_nxt.mot = HCS_JOG;
                end
                HCS_POS:
                    if (halt_s || !ready_s || pos_done)
                        st_nxt.mot = HCS_IDLE;
                HCS_JOG:
                    if (!ready_s || !(fjog_s || rjog_s))
                        st_nxt.mot = HCS_IDLE;
                default:
                    st_nxt.mot = HCS_IDLE;
            endcase
            st_nxt.fdrv = st_nxt.mot == HCS_JOG && fjog_s;
            st_nxt.rdrv = st_nxt.mot == HCS_JOG && rjog_s;
            if (ready_s)
                st_nxt.ls = camen_s ? ls_setting : LS_RESET;
            else if (offline_ls_hold == OFFLINE_ALL_OFF)
                st_nxt.ls = LS_RESET;
            // clear only where cause is gone; raise wins over clear
            if (clr_rise)
                flt_n = st_r.flt & fault_cause;
            flt_n      = flt_n | fault_event;
            st_nxt.flt = flt_n;
            if (clr_rise)
                st_nxt.any = (|flt_n) | other_error;
            else
                st_nxt.any = st_r.any | (|fault_event) | other_error;
            if (error_code_load)
                st_nxt.code = error_code_in;
            else if (clr_rise)
                st_nxt.code = ERR_CODE_CLEARED;
            st_nxt.pcommit = param_write && !ready_s;
            st_nxt.lcommit = ls_setting_write;
            st_nxt.p1 = ready_s && ((preset_mode == PRESET_SEQ_FMT) ? p1_rise
                        : (mode_inhibits(preset_mode) && ep_rise1 && !p1i_s));
            st_nxt.p2 = ready_s && mode_inhibits(preset_mode) && ep_rise2 && !p2i_s;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r      <= '0;
            st_r.mot  <= HCS_IDLE;
            st_r.ls   <= LS_RESET;
            st_r.flt  <= FAULT_RESET;
            st_r.code <= ERR_CODE_CLEARED;
        end
        else
            st_r <= st_nxt;
    end

    assign online_indicator       = st_r.online;
    // one-hot code: bit 1 is the positioning state, so the output stays a bare flop
    assign pos_active             = st_r.mot[1];
    assign pos_start_pulse        = st_r.start;
    assign forward_drive_out      = st_r.fdrv;
    assign reverse_drive_out      = st_r.rdrv;
    assign ls_out                 = st_r.ls;
    assign {upper_overtravel_flag, lower_overtravel_flag, sensor_fault_flag,
            excess_correction_flag, excess_change_flag} = st_r.flt;
    assign any_fault_flag         = st_r.any;
    assign error_code             = st_r.code;
    assign param_commit           = st_r.pcommit;
    assign ls_commit              = st_r.lcommit;
    assign preset1_fire           = st_r.p1;
    assign preset2_fire           = st_r.p2;

    chk_online_follow: assert property (@(posedge clk) disable iff (rst)
        ce |=> online_indicator == $past(ready_s)) else $error("online mismatch");
    chk_halt_abort: assert property (@(posedge clk) disable iff (rst)
        ce && halt_s |=> !pos_active && !pos_start_pulse) else $error("halt ignored");
    chk_offline_low: assert property (@(posedge clk) disable iff (rst)
        ce && !ready_s |=> !pos_active && !forward_drive_out && !reverse_drive_out)
        else $error("offline drive");
    chk_jog_block: assert property (@(posedge clk) disable iff (rst)
        pos_active |-> !forward_drive_out && !reverse_drive_out) else $error("jog in pos");
    // forward drive only from an online request
    chk_fwd_source: assert property (@(posedge clk) disable iff (rst)
        forward_drive_out |-> $past(fjog_s) && $past(ready_s)) else $error("stray fwd drive");
    // forward drive held while the request stands
    chk_fwd_hold: assert property (@(posedge clk) disable iff (rst)
        ce && st_r.mot == HCS_JOG && ready_s && fjog_s |=> forward_drive_out)
        else $error("fwd drive dropped");
    // reverse drive only from an online request
    chk_rev_source: assert property (@(posedge clk) disable iff (rst)
        reverse_drive_out |-> $past(rjog_s) && $past(ready_s)) else $error("stray rev drive");
    // reverse drive held while the request stands
    chk_rev_hold: assert property (@(posedge clk) disable iff (rst)
        ce && st_r.mot == HCS_JOG && ready_s && rjog_s |=> reverse_drive_out)
        else $error("rev drive dropped");
    // start needs online and no halt
    chk_go_start: assert property (@(posedge clk) disable iff (rst)
        pos_start_pulse |-> $past(ready_s) && !$past(halt_s) && $past(go_rise))
        else $error("bad start");
    // start refused on sensor code or operation error
    chk_go_errors: assert property (@(posedge clk) disable iff (rst)
        pos_start_pulse |-> $past(error_code) != ERR_CODE_SENSOR && !$past(channel_op_error))
        else $error("start on error");
    chk_go_jog: assert property (@(posedge clk) disable iff (rst)
        ce && st_r.mot == HCS_JOG |=> !pos_start_pulse) else $error("start in jog");
    chk_go_fault: assert property (@(posedge clk) disable iff (rst)
        ce && any_fault_flag |=> !pos_start_pulse) else $error("start on fault");
    chk_ls_off: assert property (@(posedge clk) disable iff (rst)
        ce && ready_s && !camen_s |=> ls_out == LS_RESET) else $error("ls not off");
    chk_ls_on: assert property (@(posedge clk) disable iff (rst)
        ce && ready_s && camen_s |=> ls_out == $past(ls_setting)) else $error("ls not set");
    chk_ls_offline_off: assert property (@(posedge clk) disable iff (rst)
        ce && !ready_s && offline_ls_hold == OFFLINE_ALL_OFF |=> ls_out == LS_RESET)
        else $error("offline ls on");
    chk_ls_offline_hold: assert property (@(posedge clk) disable iff (rst)
        ce && !ready_s && offline_ls_hold != OFFLINE_ALL_OFF |=> $stable(ls_out))
        else $error("offline ls moved");
    chk_clear_code: assert property (@(posedge clk) disable iff (rst)
        ce && clr_rise && !error_code_load |=> error_code == ERR_CODE_CLEARED)
        else $error("code not cleared");
    // clear drops every flag whose cause is gone, unless a fault_event raises it in the same cycle
    chk_clear_flags: assert property (@(posedge clk) disable iff (rst)
        ce && clr_rise |=> (st_r.flt & ~$past(fault_cause) & ~$past(fault_event)) == FAULT_RESET)
        else $error("flag not cleared");
    // flags fall only on a clear edge
    chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
        ce && !clr_rise |=> (st_r.flt & $past(st_r.flt)) == $past(st_r.flt))
        else $error("flag dropped");
    chk_any_fault: assert property (@(posedge clk) disable iff (rst)
        (|st_r.flt) |-> any_fault_flag) else $error("summary low");
    // summary rises with any event or other error
    chk_any_event: assert property (@(posedge clk) disable iff (rst)
        ce && ((|fault_event) || other_error) |=> any_fault_flag) else $error("summary missed");
    chk_param_gate: assert property (@(posedge clk) disable iff (rst)
        param_commit |-> !$past(ready_s, 1)) else $error("online commit");
    chk_ls_commit: assert property (@(posedge clk) disable iff (rst)
        ce && ls_setting_write |=> ls_commit) else $error("ls commit missed");
    chk_preset1_inh: assert property (@(posedge clk) disable iff (rst)
        ce && p1i_s && mode_inhibits(preset_mode) |=> !preset1_fire)
        else $error("preset1 inhibited");
    chk_preset1_cmd: assert property (@(posedge clk) disable iff (rst)
        ce && ready_s && preset_mode == PRESET_SEQ_FMT && p1_rise |=> preset1_fire)
        else $error("preset cmd missed");
    chk_preset2_inh: assert property (@(posedge clk) disable iff (rst)
        ce && p2i_s |=> !preset2_fire) else $error("preset2 inhibited");
endmodule

// ---- testbench/hcs_host_model.sv ----
`timescale 1ns/1ns
module hcs_host_model (
    input  wire logic       clk,                        // module clock
    input  wire logic       rst,                        // async reset, active high
    input  wire logic [7:0] lvl,                        // wanted command levels
    input  wire logic       clear_go,                   // ask for one error reset
    output logic            host_ready_level,           // ready level pin
    output logic            position_go_request,        // start pin
    output logic            position_halt_request,      // stop pin
    output logic            forward_jog_request,        // forward jog pin
    output logic            reverse_jog_request,        // reverse jog pin
    output logic            cam_output_enable,          // limit outputs enable pin
    output logic            preset1_inhibit_or_trigger, // preset 1 pin
    output logic            preset2_inhibit,            // preset 2 pin
    output logic            fault_clear_request         // error reset pin
);
    logic [2:0] clr_cnt_r;

    // the host program updates its outputs once per scan, here at the falling edge
    always @(negedge clk or posedge rst)
    begin
        if (rst)
        begin
            {preset2_inhibit, preset1_inhibit_or_trigger, cam_output_enable,
             reverse_jog_request, forward_jog_request, position_halt_request,
             position_go_request, host_ready_level} <= 8'h00;
            fault_clear_request <= 1'b0;
            clr_cnt_r <= 3'h0;
        end
        else
        begin
            {preset2_inhibit, preset1_inhibit_or_trigger, cam_output_enable,
             reverse_jog_request, forward_jog_request, position_halt_request,
             position_go_request, host_ready_level} <= lvl;
            // clear low again before the next
            if (clr_cnt_r != 3'h0)
                clr_cnt_r <= clr_cnt_r - 3'h1;
            else if (clear_go)
                clr_cnt_r <= 3'h7;
            fault_clear_request <= (clr_cnt_r == 3'h0) ? clear_go : (clr_cnt_r > 3'h4);
        end
    end
endmodule

// ---- testbench/host_command_signal_handler_bench.sv ----
`timescale 1ns/1ns
module host_command_signal_handler_bench;
    import hcs_pkg::*;
    localparam int RDY = 0, GO = 1, HALT = 2, FJOG = 3, REV = 4, CAM = 5, P1 = 6, P2 = 7;
    logic clk = 1'b0, rst = 1'b1, clear_go = 1'b0, ext1 = 1'b0, ext2 = 1'b0;
    logic ce = 1'b1, other_err = 1'b0;
    logic [7:0] lvl = 8'h00, ls_setting = 8'h00;
    logic [1:0] preset_mode = 2'h1;
    logic offline_ls_hold = 1'b0, pos_done = 1'b0, chan_err = 1'b0, code_load = 1'b0;
    logic [4:0] fault_event = 5'h00, fault_cause = 5'h00, flags;
    logic [15:0] code_in = 16'h0000, error_code;
    logic param_write = 1'b0, ls_write = 1'b0;
    logic rdy, go, halt, fj, rj, cam, p1, p2, fcr;
    logic online, pos_active, start_p, fdrv_o, rev_o, any_f, pc, lc, f1, f2;
    logic [7:0] ls_out, n_start = 8'h00, n_pc = 8'h00, n_lc = 8'h00, n_f1 = 8'h00, n_f2 = 8'h00;
    logic [7:0] s0, s1, s2;
    int n_fail = 0, num_checks = 0;

    initial forever #2 clk = ~clk;

    hcs_host_model hcs_host_model_i (.clk(clk), .rst(rst), .lvl(lvl), .clear_go(clear_go),
        .host_ready_level(rdy), .position_go_request(go), .position_halt_request(halt),
        .forward_jog_request(fj), .reverse_jog_request(rj), .cam_output_enable(cam),
        .preset1_inhibit_or_trigger(p1), .preset2_inhibit(p2), .fault_clear_request(fcr));

    hcs_host_cmd hcs_host_cmd_i (.clk(clk), .rst(rst), .ce(ce), .host_ready_level(rdy),
        .position_go_request(go), .position_halt_request(halt), .forward_jog_request(fj),
        .reverse_jog_request(rj), .cam_output_enable(cam), .fault_clear_request(fcr),
        .preset1_inhibit_or_trigger(p1), .preset2_inhibit(p2), .ext_preset1_in(ext1),
        .ext_preset2_in(ext2), .preset_mode(preset_mode), .offline_ls_hold(offline_ls_hold),
        .ls_setting(ls_setting), .pos_done(pos_done), .channel_op_error(chan_err),
        .fault_event(fault_event), .fault_cause(fault_cause), .other_error(other_err),
        .error_code_in(code_in), .error_code_load(code_load), .param_write(param_write),
        .ls_setting_write(ls_write), .online_indicator(online), .pos_active(pos_active),
        .pos_start_pulse(start_p), .forward_drive_out(fdrv_o), .reverse_drive_out(rev_o),
        .ls_out(ls_out), .upper_overtravel_flag(flags[4]), .lower_overtravel_flag(flags[3]),
        .sensor_fault_flag(flags[2]), .excess_correction_flag(flags[1]),
        .excess_change_flag(flags[0]), .any_fault_flag(any_f), .error_code(error_code),
        .param_commit(pc), .ls_commit(lc), .preset1_fire(f1), .preset2_fire(f2));

    // one-cycle strobes are counted so that scenarios can judge them by difference
    always @(posedge clk)
    begin
        n_start <= n_start + {7'h00, start_p};
        n_pc <= n_pc + {7'h00, pc};
        n_lc <= n_lc + {7'h00, lc};
        n_f1 <= n_f1 + {7'h00, f1};
        n_f2 <= n_f2 + {7'h00, f2};
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic set(input int i, input logic v);
        lvl[i] <= v;
        cyc(6);
    endtask

    task automatic go_edge(input logic exp);
        set(GO, 1'b1);
        chk(pos_active, exp);
        set(GO, 1'b0);
    endtask

    task automatic finish_pos;
        pos_done <= 1'b1;
        cyc(1);
        pos_done <= 1'b0;
        cyc(4);
    endtask

    task automatic clear_pulse;
        clear_go <= 1'b1;
        cyc(1);
        clear_go <= 1'b0;
        cyc(10);
    endtask

    task automatic t_online;
        set(RDY, 1'b1);
        chk(online, 1'b1);
        // with the clock enable low the block must not see the new level
        ce <= 1'b0;
        set(RDY, 1'b0);
        chk(online, 1'b1);
        ce <= 1'b1;
        cyc(6);
        chk(online, 1'b0);
        set(RDY, 1'b1);
    endtask

    task automatic t_go;
        s0 = n_start;
        go_edge(1'b1);
        chk(n_start - s0, 8'h01);
        finish_pos();
        chk(pos_active, 1'b0);
        go_edge(1'b1);
        set(HALT, 1'b1);
        chk(pos_active, 1'b0);
        go_edge(1'b0);
        set(HALT, 1'b0);
        chan_err <= 1'b1;
        go_edge(1'b0);
        chan_err <= 1'b0;
        code_in <= ERR_CODE_SENSOR;
        code_load <= 1'b1;
        cyc(1);
        code_load <= 1'b0;
        go_edge(1'b0);
        // the stored sensor code would block every later start
        clear_pulse();
        chk(error_code, ERR_CODE_CLEARED);
    endtask

    task automatic t_jog;
        for (int d = 0; d < 2; d++)
        begin
            set(FJOG + d, 1'b1);
            chk({rev_o, fdrv_o}, 2'h1 << d);
            go_edge(1'b0);
            set(FJOG + d, 1'b0);
            chk({rev_o, fdrv_o}, 2'h0);
        end
        go_edge(1'b1);
        set(REV, 1'b1);
        chk(rev_o, 1'b0);
        set(REV, 1'b0);
        set(FJOG, 1'b1);
        chk(fdrv_o, 1'b0);
        set(FJOG, 1'b0);
        set(RDY, 1'b0);
        chk(pos_active, 1'b0);
        set(FJOG, 1'b1);
        chk(fdrv_o, 1'b0);
        set(FJOG, 1'b0);
        set(RDY, 1'b1);
    endtask

    task automatic t_ls;
        ls_setting <= 8'ha5;
        set(CAM, 1'b1);
        chk(ls_out, 8'ha5);
        set(CAM, 1'b0);
        chk(ls_out, 8'h00);
        set(CAM, 1'b1);
        offline_ls_hold <= 1'b1;
        set(RDY, 1'b0);
        chk(ls_out, 8'ha5);
        offline_ls_hold <= 1'b0;
        cyc(4);
        chk(ls_out, 8'h00);
        for (int on = 0; on < 2; on++)
        begin
            s1 = n_pc;
            s2 = n_lc;
            param_write <= 1'b1;
            ls_write <= 1'b1;
            cyc(1);
            param_write <= 1'b0;
            ls_write <= 1'b0;
            cyc(4);
            chk(n_pc - s1, (on == 0) ? 8'h01 : 8'h00);
            chk(n_lc - s2, 8'h01);
            set(RDY, 1'b1);
        end
    endtask

    task automatic t_fault;
        fault_cause <= 5'h04;
        fault_event <= 5'h14;
        cyc(1);
        fault_event <= 5'h00;
        cyc(4);
        chk({flags, any_f}, 6'h29);
        go_edge(1'b0);
        for (int k = 0; k < 2; k++)
        begin
            clear_pulse();
            chk({flags, any_f}, (k == 0) ? 6'h09 : 6'h00);
            chk(error_code, ERR_CODE_CLEARED);
            fault_cause <= 5'h00;
        end
        other_err <= 1'b1;
        cyc(1);
        other_err <= 1'b0;
        cyc(4);
        chk(any_f, 1'b1);
        clear_pulse();
        chk(any_f, 1'b0);
    endtask

    task automatic t_preset;
        for (int m = 1; m < 3; m++)
        begin
            preset_mode <= m[1:0];
            for (int inh = 1; inh >= 0; inh--)
            begin
                lvl[P1] <= inh[0];
                set(P2, inh[0]);
                s1 = n_f1;
                s2 = n_f2;
                ext1 <= 1'b1;
                ext2 <= 1'b1;
                cyc(3);
                ext1 <= 1'b0;
                ext2 <= 1'b0;
                cyc(6);
                chk(n_f1 != s1, inh == 0);
                chk(n_f2 != s2, inh == 0);
            end
        end
        preset_mode <= PRESET_SEQ_FMT;
        s1 = n_f1;
        set(P1, 1'b1);
        chk(n_f1 - s1, 8'h01);
        set(P1, 1'b0);
    endtask

    task automatic results;
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #40000;
        n_fail++;
        results();
    end

    initial
    begin
        cyc(20);
        rst <= 1'b0;
        cyc(2);
        t_online();
        t_go();
        t_jog();
        t_ls();
        t_fault();
        t_preset();
        results();
    end
endmodule
